// ===== rtl/dsp_alu_regs.vh
// Constants for the DSP instruction execution block.
`ifndef DSP_ALU_REGS_VH
`define DSP_ALU_REGS_VH

// Operation codes handed over by the instruction decoder.
`define OP_CMPU 5'h00
`define OP_CNTXS 5'h01
`define OP_CNTXR 5'h02
`define OP_DINT 5'h03
`define OP_EINT 5'h04
`define OP_DIVS 5'h05
`define OP_LIM 5'h06
`define OP_LDPAGE 5'h07
`define OP_LDMODI 5'h08
`define OP_LDMODJ 5'h09
`define OP_LDSTEPI 5'h0a
`define OP_LDSTEPJ 5'h0b
`define OP_LDPS 5'h0c
`define OP_MAC 5'h0d
`define OP_MAA 5'h0e
`define OP_MAASU 5'h0f
`define OP_MACUS 5'h10
`define OP_MACUU 5'h11

// Register port indices; accumulators sit at 0x10 + 4*n + part.
`define R_ST0 5'h00
`define R_ST1 5'h01
`define R_ST2 5'h02
`define R_CFGI 5'h03
`define R_CFGJ 5'h04
`define R_X 5'h05
`define R_Y 5'h06
`define R_PL 5'h07
`define R_PH 5'h08
`define R_ACC_BIT 4

// Flag positions inside the flag byte held in status_word_0 bits 11..4, and the interrupt enable bit of status_word_0.
`define F_Z 7
`define F_M 6
`define F_N 5
`define F_V 4
`define F_C 3
`define F_E 2
`define F_L 1
`define F_R 0
`define ST0_IE 1

// Field positions of the address configuration registers.
`define CFG_MOD_LO 7

// Product shift codes.
`define PS_NONE 2'h0
`define PS_SHR1 2'h1
`define PS_SHL1 2'h2
`define PS_SHL2 2'h3

// Saturation bounds and arithmetic constants.
`define LIM_POS 36'h007ffffff
`define LIM_NEG 36'hff8000000
`define DIV_SHIFT 15
`define ALIGN_SHIFT 16

// Reset values.
`define RST16 16'h0000
`define RST36 36'h000000000
`define RST32 32'h00000000

`endif

// ===== rtl/dsp_alu_mac_instr_exec.v
// Execution unit for compare, context, divide step, limit, load and multiply-accumulate operations.
// Summary of operation
// - Unsigned compare subtracts zero-extended operand, flags only.
// - Context store copies status groups to shadows.
// - Context restore reloads status groups from shadows.
// - Both directions swap page bits with alternate.
// - Both directions swap second accumulators in one cycle.
// - Store flags Z,M,N,E follow new second_a value.
// - Restore writes all eight flags from shadows.
// - Disable clears, enable sets interrupt enable.
// - Division step: conditional subtract, shift, quotient bit.
// - Limit saturates, optionally into other accumulator.
// - Page load writes 8-bit constant into status_word_1.
// - Modulo load writes 9-bit high config field.
// - Step load writes 7-bit low config field.
// - Product shift field codes select none, right one, left one or left two.
// - Signed MAC adds shifted product, loads, multiplies.
// - Previous product sign-extended to 36, zero-extended after MACUU, then shifted.
// - Aligned forms shift product right sixteen more.
// - Variants select operand signedness per instruction.
// - Dual pointer form reads Y and X/Z spaces.
// - MAC takes one cycle, two with immediate or dual pointer.
`timescale 1ns/1ps
`include "dsp_alu_regs.vh"

module dsp_alu_mac_instr_exec (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Decoded instruction.
  input wire opValid,
  input wire [4:0] opCode,
  input wire accSel,
  input wire limOther,
  input wire opLongImm,
  input wire opDualPtr,
  input wire opUseY,
  input wire [15:0] opData1,
  input wire [15:0] opData2,
  input wire [15:0] immWord,
  input wire [15:0] ySpacePointer,
  input wire [15:0] xzSpacePointer,
  // Data memory reads.
  output reg [15:0] yAddr_ff,
  output reg yRdEn_ff,
  output reg [15:0] xzAddr_ff,
  output reg xzRdEn_ff,
  input wire [15:0] yRdData,
  input wire [15:0] xzRdData,
  // Register port.
  input wire [4:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData_ff,
  // Status.
  output reg busy_ff,
  output reg globalIrqEnable_ff
);

  localparam S_IDLE = 3'b001;
  localparam S_FETCH = 3'b010;
  localparam S_IMM = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [35:0] a0_ff, a1_ff, b0_ff, b1_ff;
  reg [35:0] nxt_a0, nxt_a1, nxt_b0, nxt_b1;
  reg [7:0] flags_ff, nxt_flags;
  reg [2:0] st0Misc_ff, nxt_st0Misc;
  reg nxt_ie;
  reg [7:0] page_ff, nxt_page;
  reg [7:0] pageAlt_ff, nxt_pageAlt;
  reg [1:0] ps_ff, nxt_ps;
  reg [7:0] st2_ff, nxt_st2;
  reg [15:0] cfgi_ff, nxt_cfgi, cfgj_ff, nxt_cfgj;
  reg [15:0] x_ff, nxt_x, y_ff, nxt_y;
  reg [31:0] p_ff, nxt_p;
  reg pUns_ff, nxt_pUns;
  reg [7:0] shFlags_ff, nxt_shFlags;
  reg [2:0] shMisc_ff, nxt_shMisc;
  reg [1:0] shPs_ff, nxt_shPs;
  reg [7:0] shSt2_ff, nxt_shSt2;
  reg [4:0] pendOp_ff;
  reg pendAcc_ff, pendOther_ff, pendUseY_ff;
  reg [15:0] pendData1_ff;
  reg exGo, exAcc, exOther, exUseY;
  reg [4:0] exOp;
  reg [15:0] op1, op2, yOp;
  reg [35:0] accCur, accRes, sp, dv, diff;
  reg [36:0] sum;
  reg accWr, ovf;
  reg [15:0] rdMux;

  // Sign- or zero-extends the product, applies the shift code, then the optional alignment.
  function [35:0] shiftP(input [31:0] p, input uns, input [1:0] ps, input aligned);
    reg [35:0] e;
    reg [35:0] s;
    begin
      e = uns ? {4'h0, p} : {{4{p[31]}}, p};
      case (ps)
        `PS_SHR1: s = {e[35], e[35:1]};
        `PS_SHL1: s = {e[34:0], 1'b0};
        `PS_SHL2: s = {e[33:0], 2'b00};
        default: s = e;
      endcase
      shiftP = aligned ? {{`ALIGN_SHIFT{s[35]}}, s[35:`ALIGN_SHIFT]} : s;
    end
  endfunction

  // Multiplies two words, each taken as signed or unsigned.
  function [31:0] mulOp(input [15:0] a, input [15:0] b, input sa, input sb);
    reg signed [16:0] ea;
    reg signed [16:0] eb;
    reg signed [33:0] pr;
    begin
      ea = {sa & a[15], a};
      eb = {sb & b[15], b};
      pr = ea * eb;
      mulOp = pr[31:0];
    end
  endfunction

  // Updates zero, minus, normalized and extension flags, and optionally V, C and the sticky L.
  function [7:0] setFlags(input [7:0] old, input [35:0] v, input useVc, input ov, input cy);
    reg [7:0] f;
    reg ext;
    begin
      f = old;
      ext = ~((&v[35:31]) | ~(|v[35:31]));
      f[`F_Z] = ~(|v);
      f[`F_M] = v[35];
      f[`F_E] = ext;
      f[`F_N] = ~ext & (v[31] ^ v[30]);
      if (useVc)
      begin
        f[`F_V] = ov;
        f[`F_C] = cy;
        f[`F_L] = old[`F_L] | ov;
      end
      setFlags = f;
    end
  endfunction

  // Replaces one 16-bit part of an accumulator written from the register port.
  function [35:0] putPart(input [35:0] v, input [1:0] part, input [15:0] d);
    begin
      case (part)
        2'h0: putPart = {v[35:16], d};
        2'h1: putPart = {v[35:32], d, v[15:0]};
        2'h2: putPart = {d[3:0], v[31:0]};
        default: putPart = v;
      endcase
    end
  endfunction

  // Reads one 16-bit part of an accumulator, extension sign-filled.
  function [15:0] getPart(input [35:0] v, input [1:0] part);
    begin
      case (part)
        2'h0: getPart = v[15:0];
        2'h1: getPart = v[31:16];
        2'h2: getPart = {{12{v[35]}}, v[35:32]};
        default: getPart = 16'h0000;
      endcase
    end
  endfunction

  // Selects the operation to execute this cycle and the next sequencing state.
  always @*
  begin
    exGo = 1'b0;
    exOp = opCode;
    exAcc = accSel;
    exOther = limOther;
    exUseY = opUseY;
    op1 = opData1;
    op2 = opData2;
    nxt_state = S_IDLE;
    case (state_ff)
      S_IDLE:
      begin
        if (opValid && opDualPtr)
          nxt_state = S_FETCH;
        else if (opValid && opLongImm)
          nxt_state = S_IMM;
        else
          exGo = opValid;
      end
      S_FETCH:
      begin
        exGo = 1'b1;
        exOp = pendOp_ff;
        exAcc = pendAcc_ff;
        exOther = pendOther_ff;
        exUseY = 1'b0;
        op1 = yRdData;
        op2 = xzRdData;
      end
      S_IMM:
      begin
        exGo = 1'b1;
        exOp = pendOp_ff;
        exAcc = pendAcc_ff;
        exOther = pendOther_ff;
        exUseY = pendUseY_ff;
        op1 = pendData1_ff;
        op2 = immWord;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // Computes every next architectural register value: register port writes first, execution overrides.
  always @*
  begin
    nxt_a0 = a0_ff;
    nxt_a1 = a1_ff;
    nxt_b0 = b0_ff;
    nxt_b1 = b1_ff;
    nxt_flags = flags_ff;
    nxt_st0Misc = st0Misc_ff;
    nxt_ie = globalIrqEnable_ff;
    nxt_page = page_ff;
    nxt_pageAlt = pageAlt_ff;
    nxt_ps = ps_ff;
    nxt_st2 = st2_ff;
    nxt_cfgi = cfgi_ff;
    nxt_cfgj = cfgj_ff;
    nxt_x = x_ff;
    nxt_y = y_ff;
    nxt_p = p_ff;
    nxt_pUns = pUns_ff;
    nxt_shFlags = shFlags_ff;
    nxt_shMisc = shMisc_ff;
    nxt_shPs = shPs_ff;
    nxt_shSt2 = shSt2_ff;
    accCur = exAcc ? a1_ff : a0_ff;
    accRes = accCur;
    accWr = 1'b0;
    ovf = 1'b0;
    sum = 37'h000000000;
    sp = `RST36;
    dv = `RST36;
    diff = `RST36;
    yOp = exUseY ? y_ff : op1;
    if (regWr)
    begin
      if (regAddr[`R_ACC_BIT])
      begin
        case (regAddr[3:2])
          2'h0: nxt_a0 = putPart(a0_ff, regAddr[1:0], regWrData);
          2'h1: nxt_a1 = putPart(a1_ff, regAddr[1:0], regWrData);
          2'h2: nxt_b0 = putPart(b0_ff, regAddr[1:0], regWrData);
          default: nxt_b1 = putPart(b1_ff, regAddr[1:0], regWrData);
        endcase
      end
      else
      begin
        case (regAddr)
          `R_ST0:
          begin
            nxt_flags = regWrData[11:4];
            nxt_st0Misc = {regWrData[3:2], regWrData[0]};
            nxt_ie = regWrData[`ST0_IE];
          end
          `R_ST1:
          begin
            nxt_ps = regWrData[11:10];
            nxt_page = regWrData[7:0];
          end
          `R_ST2: nxt_st2 = regWrData[7:0];
          `R_CFGI: nxt_cfgi = regWrData;
          `R_CFGJ: nxt_cfgj = regWrData;
          `R_X: nxt_x = regWrData;
          `R_Y: nxt_y = regWrData;
          `R_PL: nxt_p = {p_ff[31:16], regWrData};
          `R_PH:
          begin
            nxt_p = {regWrData, p_ff[15:0]};
            nxt_pUns = 1'b0;
          end
          default: nxt_x = x_ff;
        endcase
      end
    end
    if (exGo)
    begin
      case (exOp)
        `OP_CMPU:
        begin
          sum = {1'b0, accCur} + {1'b0, ~{20'h00000, op1}} + 37'h000000001;
          ovf = (accCur[35] != 1'b0) & (sum[35] != accCur[35]);
          nxt_flags = setFlags(flags_ff, sum[35:0], 1'b1, ovf, sum[36]);
        end
        `OP_CNTXS, `OP_CNTXR:
        begin
          nxt_page = pageAlt_ff;
          nxt_pageAlt = page_ff;
          nxt_a1 = b1_ff;
          nxt_b1 = a1_ff;
          if (exOp == `OP_CNTXS)
          begin
            nxt_shFlags = flags_ff;
            nxt_shMisc = st0Misc_ff;
            nxt_shPs = ps_ff;
            nxt_shSt2 = st2_ff;
            nxt_flags = setFlags(flags_ff, b1_ff, 1'b0, 1'b0, 1'b0);
          end
          else
          begin
            nxt_flags = shFlags_ff;
            nxt_st0Misc = shMisc_ff;
            nxt_ps = shPs_ff;
            nxt_st2 = shSt2_ff;
          end
        end
        `OP_DINT: nxt_ie = 1'b0;
        `OP_EINT: nxt_ie = 1'b1;
        `OP_DIVS:
        begin
          dv = {{5{op1[15]}}, op1, {`DIV_SHIFT{1'b0}}};
          diff = accCur - dv;
          accRes = diff[35] ? {accCur[34:0], 1'b0} : {diff[34:0], 1'b1};
          accWr = 1'b1;
          nxt_flags = setFlags(flags_ff, accRes, 1'b0, 1'b0, 1'b0);
        end
        `OP_LIM:
        begin
          accWr = 1'b1;
          nxt_flags = flags_ff;
          if ($signed(accCur) > $signed(`LIM_POS))
          begin
            accRes = `LIM_POS;
            nxt_flags[`F_L] = 1'b1;
          end
          else if ($signed(accCur) < $signed(`LIM_NEG))
          begin
            accRes = `LIM_NEG;
            nxt_flags[`F_L] = 1'b1;
          end
          nxt_flags = setFlags(nxt_flags, accRes, 1'b0, 1'b0, 1'b0);
          nxt_flags[`F_E] = 1'b0;
        end
        `OP_LDPAGE: nxt_page = op1[7:0];
        `OP_LDMODI: nxt_cfgi = {op1[8:0], cfgi_ff[`CFG_MOD_LO-1:0]};
        `OP_LDMODJ: nxt_cfgj = {op1[8:0], cfgj_ff[`CFG_MOD_LO-1:0]};
        `OP_LDSTEPI: nxt_cfgi = {cfgi_ff[15:`CFG_MOD_LO], op1[6:0]};
        `OP_LDSTEPJ: nxt_cfgj = {cfgj_ff[15:`CFG_MOD_LO], op1[6:0]};
        `OP_LDPS: nxt_ps = op1[1:0];
        `OP_MAC, `OP_MAA, `OP_MAASU, `OP_MACUS, `OP_MACUU:
        begin
          sp = shiftP(p_ff, pUns_ff, ps_ff, (exOp == `OP_MAA) || (exOp == `OP_MAASU));
          sum = {1'b0, accCur} + {1'b0, sp};
          ovf = (accCur[35] == sp[35]) & (sum[35] != accCur[35]);
          accRes = sum[35:0];
          accWr = 1'b1;
          nxt_flags = setFlags(flags_ff, accRes, 1'b1, ovf, sum[36]);
          nxt_y = yOp;
          nxt_x = op2;
          nxt_p = mulOp(yOp, op2, (exOp != `OP_MACUS) && (exOp != `OP_MACUU),
                        (exOp != `OP_MAASU) && (exOp != `OP_MACUU));
          nxt_pUns = (exOp == `OP_MACUU);
        end
        default: accWr = 1'b0;
      endcase
      if (accWr)
      begin
        if (exAcc ^ ((exOp == `OP_LIM) & exOther))
          nxt_a1 = accRes;
        else
          nxt_a0 = accRes;
      end
    end
  end

  // Builds the register read word.
  always @*
  begin
    rdMux = 16'h0000;
    if (regAddr[`R_ACC_BIT])
    begin
      case (regAddr[3:2])
        2'h0: rdMux = getPart(a0_ff, regAddr[1:0]);
        2'h1: rdMux = getPart(a1_ff, regAddr[1:0]);
        2'h2: rdMux = getPart(b0_ff, regAddr[1:0]);
        default: rdMux = getPart(b1_ff, regAddr[1:0]);
      endcase
    end
    else
    begin
      case (regAddr)
        `R_ST0: rdMux = {4'h0, flags_ff, st0Misc_ff[2:1], globalIrqEnable_ff, st0Misc_ff[0]};
        `R_ST1: rdMux = {4'h0, ps_ff, 2'h0, page_ff};
        `R_ST2: rdMux = {8'h00, st2_ff};
        `R_CFGI: rdMux = cfgi_ff;
        `R_CFGJ: rdMux = cfgj_ff;
        `R_X: rdMux = x_ff;
        `R_Y: rdMux = y_ff;
        `R_PL: rdMux = p_ff[15:0];
        `R_PH: rdMux = p_ff[31:16];
        default: rdMux = 16'h0000;
      endcase
    end
  end

  // Sequencing, memory requests and the architectural register state.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= S_IDLE;
      busy_ff <= 1'b0;
      yAddr_ff <= `RST16;
      xzAddr_ff <= `RST16;
      yRdEn_ff <= 1'b0;
      xzRdEn_ff <= 1'b0;
      regRdData_ff <= `RST16;
      pendOp_ff <= 5'h00;
      pendAcc_ff <= 1'b0;
      pendOther_ff <= 1'b0;
      pendUseY_ff <= 1'b0;
      pendData1_ff <= `RST16;
      a0_ff <= `RST36;
      a1_ff <= `RST36;
      b0_ff <= `RST36;
      b1_ff <= `RST36;
      flags_ff <= 8'h00;
      st0Misc_ff <= 3'h0;
      globalIrqEnable_ff <= 1'b0;
      page_ff <= 8'h00;
      pageAlt_ff <= 8'h00;
      ps_ff <= `PS_NONE;
      st2_ff <= 8'h00;
      cfgi_ff <= `RST16;
      cfgj_ff <= `RST16;
      x_ff <= `RST16;
      y_ff <= `RST16;
      p_ff <= `RST32;
      pUns_ff <= 1'b0;
      shFlags_ff <= 8'h00;
      shMisc_ff <= 3'h0;
      shPs_ff <= `PS_NONE;
      shSt2_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != S_IDLE);
      yRdEn_ff <= (nxt_state == S_FETCH);
      xzRdEn_ff <= (nxt_state == S_FETCH);
      if (nxt_state == S_FETCH)
      begin
        yAddr_ff <= ySpacePointer;
        xzAddr_ff <= xzSpacePointer;
      end
      if (state_ff == S_IDLE)
      begin
        pendOp_ff <= opCode;
        pendAcc_ff <= accSel;
        pendOther_ff <= limOther;
        pendUseY_ff <= opUseY;
        pendData1_ff <= opData1;
      end
      regRdData_ff <= regRd ? rdMux : 16'h0000;
      a0_ff <= nxt_a0;
      a1_ff <= nxt_a1;
      b0_ff <= nxt_b0;
      b1_ff <= nxt_b1;
      flags_ff <= nxt_flags;
      st0Misc_ff <= nxt_st0Misc;
      globalIrqEnable_ff <= nxt_ie;
      page_ff <= nxt_page;
      pageAlt_ff <= nxt_pageAlt;
      ps_ff <= nxt_ps;
      st2_ff <= nxt_st2;
      cfgi_ff <= nxt_cfgi;
      cfgj_ff <= nxt_cfgj;
      x_ff <= nxt_x;
      y_ff <= nxt_y;
      p_ff <= nxt_p;
      pUns_ff <= nxt_pUns;
      shFlags_ff <= nxt_shFlags;
      shMisc_ff <= nxt_shMisc;
      shPs_ff <= nxt_shPs;
      shSt2_ff <= nxt_shSt2;
    end
  end

endmodule

// ===== bench/dsp_mem_model.sv
// Behavioural Y and X/Z data memories for the execution block.
`timescale 1ns/1ps
module dsp_mem_model (
  // Read requests.
  input wire [15:0] yAddr,
  input wire yRdEn,
  input wire [15:0] xzAddr,
  input wire xzRdEn,
  // Read data.
  output wire [15:0] yRdData,
  output wire [15:0] xzRdData
);
  // Word is the address plus an offset; with no strobe the bus shows the inverse.
  assign yRdData = yRdEn ? yAddr + 16'h0100 : ~(yAddr + 16'h0100);
  assign xzRdData = xzRdEn ? xzAddr + 16'h0200 : ~(xzAddr + 16'h0200);
endmodule

// ===== bench/dsp_alu_mac_instr_exec_sva.sv
// Port checker for the instruction execution block.
`timescale 1ns/1ps
`include "dsp_alu_regs.vh"
module dsp_alu_mac_instr_exec_sva (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Instruction inputs.
  input wire opValid,
  input wire [4:0] opCode,
  input wire opLongImm,
  input wire opDualPtr,
  input wire [15:0] ySpacePointer,
  input wire [15:0] xzSpacePointer,
  // Observed outputs.
  input wire [15:0] yAddr_ff,
  input wire yRdEn_ff,
  input wire [15:0] xzAddr_ff,
  input wire xzRdEn_ff,
  input wire busy_ff,
  input wire globalIrqEnable_ff
);
  // An instruction is accepted only while the unit is idle.
  wire take;
  assign take = opValid && !busy_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Cycle counts and memory fetch timing.
  busy_long_a: assert property (take && opLongImm |=> busy_ff)
    else $error("long op did not stall");
  busy_pulse_a: assert property (busy_ff |=> !busy_ff)
    else $error("busy longer than one cycle");
  single_fast_a: assert property (take && !opLongImm && !opDualPtr |=> !busy_ff)
    else $error("one word op stalled");
  ptr_fetch_a: assert property (take && opDualPtr |=> yRdEn_ff && xzRdEn_ff
    && yAddr_ff == $past(ySpacePointer) && xzAddr_ff == $past(xzSpacePointer))
    else $error("pointer fetch wrong");
  strobe_pulse_a: assert property (yRdEn_ff |=> !yRdEn_ff && !xzRdEn_ff)
    else $error("read strobe too long");
  // Interrupt enable handling.
  irq_off_a: assert property (take && opCode == `OP_DINT |=> !globalIrqEnable_ff)
    else $error("disable failed");
  irq_on_a: assert property (take && opCode == `OP_EINT |=> globalIrqEnable_ff)
    else $error("enable failed");
  refuse_busy_a: assert property (opValid && busy_ff |=> $stable(globalIrqEnable_ff))
    else $error("op taken while busy");
endmodule

bind dsp_alu_mac_instr_exec dsp_alu_mac_instr_exec_sva chk (.clk(clk), .arst_n(arst_n), .opValid(opValid),
  .opCode(opCode), .opLongImm(opLongImm), .opDualPtr(opDualPtr), .ySpacePointer(ySpacePointer),
  .xzSpacePointer(xzSpacePointer), .yAddr_ff(yAddr_ff), .yRdEn_ff(yRdEn_ff), .xzAddr_ff(xzAddr_ff),
  .xzRdEn_ff(xzRdEn_ff), .busy_ff(busy_ff), .globalIrqEnable_ff(globalIrqEnable_ff));

// ===== bench/tb_dsp_alu_mac_instr_exec.sv
// Self-checking testbench for the instruction execution block.
`timescale 1ns/1ps
`include "dsp_alu_regs.vh"
module tb_dsp_alu_mac_instr_exec;
  localparam [4:0] ACC_MAIN = 5'h10;
  localparam [4:0] ACC_SEC = 5'h14;
  localparam [4:0] ACC_SECB = 5'h1c;
  logic clk, arst_n, opValid, accSel, limOther, opLongImm, opDualPtr, opUseY, regWr, regRd;
  logic [4:0] opCode, regAddr;
  logic [15:0] opData1, opData2, immWord, ySpacePointer, xzSpacePointer, regWrData;
  wire [15:0] yAddr_ff, xzAddr_ff, regRdData_ff, yRdData, xzRdData;
  wire yRdEn_ff, xzRdEn_ff, busy_ff, globalIrqEnable_ff;
  logic [35:0] shiftExp [4] = '{36'h000000008, 36'h000000004, 36'h000000010, 36'h000000020};
  int errors, tests_run, k;
  // Design and its memory partner.
  dsp_alu_mac_instr_exec DUT (.clk(clk), .arst_n(arst_n), .opValid(opValid), .opCode(opCode), .accSel(accSel),
    .limOther(limOther), .opLongImm(opLongImm), .opDualPtr(opDualPtr), .opUseY(opUseY), .opData1(opData1),
    .opData2(opData2), .immWord(immWord), .ySpacePointer(ySpacePointer), .xzSpacePointer(xzSpacePointer),
    .yAddr_ff(yAddr_ff), .yRdEn_ff(yRdEn_ff), .xzAddr_ff(xzAddr_ff), .xzRdEn_ff(xzRdEn_ff), .yRdData(yRdData),
    .xzRdData(xzRdData), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData_ff(regRdData_ff), .busy_ff(busy_ff), .globalIrqEnable_ff(globalIrqEnable_ff));
  dsp_mem_model mem (.yAddr(yAddr_ff), .yRdEn(yRdEn_ff), .xzAddr(xzAddr_ff), .xzRdEn(xzRdEn_ff),
    .yRdData(yRdData), .xzRdData(xzRdData));
  // Clock generator.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compares one result word and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register port write and masked read.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData_ff & m, e);
  endtask
  // Whole accumulator write and check.
  task automatic wa(input logic [4:0] b, input logic [35:0] v);
    wr(b, v[15:0]);
    wr(b + 5'h01, v[31:16]);
    wr(b + 5'h02, {12'h000, v[35:32]});
  endtask
  task automatic ra(input logic [4:0] b, input logic [35:0] v);
    rd(b, 16'hffff, v[15:0]);
    rd(b + 5'h01, 16'hffff, v[31:16]);
    rd(b + 5'h02, 16'hffff, {{12{v[35]}}, v[35:32]});
  endtask
  // Issues one instruction; a long form offers a disable while the unit is busy.
  task automatic op(input logic [4:0] c, input logic [15:0] d1, input logic [15:0] d2, input logic [2:0] md);
    @(posedge clk);
    opValid <= 1'b1;
    opCode <= c;
    {opUseY, opDualPtr, opLongImm} <= md;
    opData1 <= d1;
    opData2 <= md[0] ? ~d2 : d2;
    immWord <= md[0] ? d2 : ~d2;
    ySpacePointer <= d1;
    xzSpacePointer <= d2;
    @(posedge clk);
    if (md[0])
      opCode <= `OP_DINT;
    else
      opValid <= 1'b0;
    if (md[1:0] != 2'b00)
    begin
      #1;
      chk({15'h0000, busy_ff}, 16'h0001);
      @(posedge clk);
      opValid <= 1'b0;
    end
  endtask
  // Accumulates a preset product into a cleared accumulator.
  task automatic macp(input logic [4:0] c, input logic [31:0] pv, input logic [35:0] e);
    wr(`R_PL, pv[15:0]);
    wr(`R_PH, pv[31:16]);
    wa(ACC_MAIN, 36'h000000000);
    op(c, 16'h0000, 16'h0000, 3'h0);
    ra(ACC_MAIN, e);
  endtask
  task automatic prod(input logic [4:0] c, input logic [15:0] y, input logic [15:0] x, input logic [31:0] e);
    op(c, y, x, 3'h0);
    rd(`R_PL, 16'hffff, e[15:0]);
    rd(`R_PH, 16'hffff, e[31:16]);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial
  begin
    #(40 * 6000);
    errors++;
    report_and_stop;
  end
  // Main test sequence.
  initial
  begin
    {opValid, accSel, limOther, opLongImm, opDualPtr, opUseY, regWr, regRd} = 8'h00;
    {opCode, regAddr} = 10'h000;
    {opData1, opData2, immWord, ySpacePointer, xzSpacePointer, regWrData} = {6{16'h0000}};
    errors = 0;
    tests_run = 0;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    op(`OP_LDPAGE, 16'hffa5, 16'h0000, 3'h0);
    rd(`R_ST1, 16'hffff, 16'h00a5);
    op(`OP_LDMODI, 16'hffff, 16'h0000, 3'h0);
    rd(`R_CFGI, 16'hffff, 16'hff80);
    op(`OP_LDSTEPI, 16'hfe05, 16'h0000, 3'h0);
    rd(`R_CFGI, 16'hffff, 16'hff85);
    op(`OP_LDMODJ, 16'h0001, 16'h0000, 3'h0);
    rd(`R_CFGJ, 16'hffff, 16'h0080);
    op(`OP_EINT, 16'h0000, 16'h0000, 3'h0);
    rd(`R_ST0, 16'h0002, 16'h0002);
    op(`OP_DINT, 16'h0000, 16'h0000, 3'h0);
    rd(`R_ST0, 16'h0002, 16'h0000);
    $display("loads and interrupt enable done");
    wa(ACC_MAIN, 36'h010000000);
    op(`OP_LIM, 16'h0000, 16'h0000, 3'h0);
    ra(ACC_MAIN, 36'h007ffffff);
    rd(`R_ST0, 16'h0060, 16'h0020);
    wa(ACC_MAIN, 36'hf00000000);
    @(posedge clk) limOther <= 1'b1;
    op(`OP_LIM, 16'h0000, 16'h0000, 3'h0);
    limOther <= 1'b0;
    ra(ACC_SEC, 36'hff8000000);
    ra(ACC_MAIN, 36'hf00000000);
    wa(ACC_MAIN, 36'h000000064);
    for (k = 0; k < 16; k++)
      op(`OP_DIVS, 16'h0007, 16'h0000, 3'h0);
    ra(ACC_MAIN, 36'h00002000e);
    wa(ACC_MAIN, 36'h000000005);
    op(`OP_CMPU, 16'hfffe, 16'h0000, 3'h0);
    rd(`R_ST0, 16'h0c00, 16'h0400);
    ra(ACC_MAIN, 36'h000000005);
    $display("limit, divide and compare done");
    for (k = 0; k < 4; k++)
    begin
      op(`OP_LDPS, k[15:0], 16'h0000, 3'h0);
      rd(`R_ST1, 16'h0c00, {k[5:0], 10'h000});
      macp(`OP_MAC, 32'h00000008, shiftExp[k]);
    end
    op(`OP_LDPS, 16'h0000, 16'h0000, 3'h0);
    macp(`OP_MAC, 32'h80000000, 36'hf80000000);
    macp(`OP_MAA, 32'h00030000, 36'h000000003);
    macp(`OP_MAA, 32'h80000000, 36'hfffff8000);
    prod(`OP_MAC, 16'hffff, 16'hffff, 32'h00000001);
    prod(`OP_MACUU, 16'hffff, 16'hffff, 32'hfffe0001);
    prod(`OP_MACUS, 16'hffff, 16'h0002, 32'h0001fffe);
    prod(`OP_MAASU, 16'hffff, 16'h0002, 32'hfffffffe);
    op(`OP_EINT, 16'h0000, 16'h0000, 3'h0);
    op(`OP_MAC, 16'h0004, 16'h0005, 3'h1);
    rd(`R_PL, 16'hffff, 16'h0014);
    rd(`R_ST0, 16'h0002, 16'h0002);
    op(`OP_MAC, 16'h0003, 16'h0005, 3'h2);
    rd(`R_Y, 16'hffff, 16'h0103);
    rd(`R_X, 16'hffff, 16'h0205);
    rd(`R_PL, 16'hffff, 16'h0b0f);
    op(`OP_MAC, 16'h7777, 16'h0002, 3'h4);
    rd(`R_Y, 16'hffff, 16'h0103);
    rd(`R_PL, 16'hffff, 16'h0206);
    $display("multiply-accumulate done");
    wr(`R_ST2, 16'h005a);
    op(`OP_LDPAGE, 16'h0033, 16'h0000, 3'h0);
    op(`OP_LDPS, 16'h0001, 16'h0000, 3'h0);
    wr(`R_ST0, 16'h0010);
    wa(ACC_SEC, 36'h000001234);
    wa(ACC_SECB, 36'h000000000);
    op(`OP_CNTXS, 16'h0000, 16'h0000, 3'h0);
    rd(`R_ST0, 16'hffff, 16'h0810);
    ra(ACC_SEC, 36'h000000000);
    ra(ACC_SECB, 36'h000001234);
    rd(`R_ST1, 16'hffff, 16'h0400);
    wr(`R_ST2, 16'h0000);
    op(`OP_LDPS, 16'h0000, 16'h0000, 3'h0);
    op(`OP_LDPAGE, 16'h0077, 16'h0000, 3'h0);
    op(`OP_CNTXR, 16'h0000, 16'h0000, 3'h0);
    rd(`R_ST2, 16'h00ff, 16'h005a);
    rd(`R_ST1, 16'hffff, 16'h0433);
    rd(`R_ST0, 16'hffff, 16'h0010);
    ra(ACC_SEC, 36'h000001234);
    $display("context switch done");
    report_and_stop;
  end
endmodule
